// ==== common/sequencer_params.svh ====
// Address map, field positions, reset values and timing constants
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH

// Clock rate and time base
`define CLK_HZ 50000000
`define SEC_PERIOD_S 1
`define SEC_PER_MIN 6'h3C
`define MIN_PER_HOUR 6'h3C

// Register byte addresses
`define ADDR_CONTROL 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_RANGE 8'h08
`define ADDR_FLOOR 8'h0C
`define ADDR_CEILING 8'h10
`define ADDR_CONTACT 8'h14
`define ADDR_TARGET 8'h18
`define ADDR_RESUME 8'h1C
`define ADDR_STATUS 8'h20
`define ADDR_SETPOINT 8'h24
`define ADDR_STEP_BASE 8'h40
`define ADDR_STEP_LAST 8'hBC

// Field positions
`define CTL_RUN 0
`define CTL_REMOTE 1
`define CTL_PWR_RET 2
`define CFG_COUNT_LSB 0
`define CFG_TYPE_LSB 4
`define CFG_UNIT_LSB 6
`define SEL_WIDTH 5
`define STEP_FLD_TARGET 2'h0
`define STEP_FLD_RATE 2'h1
`define STEP_FLD_DUR 2'h2
`define STEP_FLD_GROUP 2'h3

// Sizes, codes and reset values
`define NUM_CONTACTS 5
`define NUM_STEPS 8
`define SEL_NONE 5'h00
`define SEL_RAMP_CTL 5'h0D
`define COUNT_RST 4'h1
`define COUNT_MIN 4'h1
`define COUNT_MAX 4'h8
`define TYPE_RST 2'h0
`define TYPE_STEP_STOP 2'h2
`define TYPE_STEP_RESUME 2'h3
`define UNIT_RST 2'h1
`define UNIT_PER_SEC 2'h0
`define UNIT_PER_MIN 2'h1
`define UNIT_PER_HOUR 2'h2
`define GROUP_RST 4'h1
`define RANGE_RST 8'h00
`define FRAC_ONE 16'h000A

`endif

// ==== common/sequencer_pkg.sv ====
// Types shared by the setpoint sequencer files
package sequencer_pkg;

  typedef struct packed {
    logic signed [15:0] target;
    logic [15:0] rate;
    logic [15:0] dur;
    logic [3:0] grp;
  } step_entry_t;

  typedef struct packed {
    logic running;
    logic soak;
    logic [2:0] step;
  } progress_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_SOAK = 2'b10
  } seq_state_t;

endpackage

// ==== rtl/bound_clamp.sv ====
// Orders two bounds and clamps a value between them
`timescale 1ns/10ps
module bound_clamp (
  // Bounds as configured
  input wire logic signed [15:0] bound_a,
  input wire logic signed [15:0] bound_b,
  // Value to limit
  input wire logic signed [15:0] value,
  // Ordered bounds and result
  output logic signed [15:0] lo,
  output logic signed [15:0] hi,
  output logic signed [15:0] clamped
);
  always_comb begin
    // A floor above the ceiling is taken the other way round
    if (bound_a > bound_b) begin
      lo = bound_b;
      hi = bound_a;
    end else begin
      lo = bound_a;
      hi = bound_b;
    end
    if (value < lo) begin
      clamped = lo;
    end else if (value > hi) begin
      clamped = hi;
    end else begin
      clamped = value;
    end
  end
endmodule

// ==== rtl/tick_gen.sv ====
// Second, minute and hour pulses from the system clock
`timescale 1ns/10ps
`include "sequencer_params.svh"
module tick_gen #(
  parameter int unsigned SEC_CYCLES = `SEC_PERIOD_S * `CLK_HZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // One-cycle pulses
  output logic sec_tick,
  output logic min_tick,
  output logic hour_tick
);
  localparam int CW = $clog2(SEC_CYCLES);
  logic [CW-1:0] cyc_ff;
  logic [5:0] sec_ff;
  logic [5:0] min_ff;
  logic sec_wrap;
  logic min_wrap;

  assign sec_wrap = (sec_ff == `SEC_PER_MIN - 6'h01);
  assign min_wrap = (min_ff == `MIN_PER_HOUR - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= '0;
      sec_ff <= 6'h00;
      min_ff <= 6'h00;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      hour_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      hour_tick <= 1'b0;
      if (cyc_ff == CW'(SEC_CYCLES - 1)) begin
        cyc_ff <= '0;
        sec_tick <= 1'b1;
        sec_ff <= sec_wrap ? 6'h00 : sec_ff + 6'h01;
        if (sec_wrap) begin
          min_tick <= 1'b1;
          min_ff <= min_wrap ? 6'h00 : min_ff + 6'h01;
          hour_tick <= min_wrap;
        end
      end else begin
        cyc_ff <= cyc_ff + CW'(1);
      end
    end
  end
endmodule

// ==== rtl/setpoint_step_sequencer.sv ====
// Setpoint limiting, ramp suspend and step programme sequencer with APB registers
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "sequencer_params.svh"
module setpoint_step_sequencer #(
  parameter int unsigned SEC_CYCLES = `SEC_PERIOD_S * `CLK_HZ
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement side
  input wire logic signed [15:0] measured_value,
  input wire logic signed [15:0] span_low,
  input wire logic signed [15:0] span_high,
  input wire logic [1:0] measurement_alarm_pair,
  input wire logic [`NUM_CONTACTS-1:0] contact_state,
  // Controller side
  output logic signed [15:0] working_setpoint,
  output logic [3:0] tuning_group,
  output sequencer_pkg::progress_t progress,
  output logic remote_source_active,
  output logic ramp_inhibited,
  // Nonvolatile progress log
  output logic nv_write,
  output sequencer_pkg::progress_t nv_record
);
  import sequencer_pkg::*;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic run_ff;
  logic remote_req_ff;
  logic remote_active_ff;
  logic [3:0] count_ff;
  logic [1:0] type_ff;
  logic [1:0] unit_ff;
  logic [7:0] range_type_ff;
  logic signed [15:0] floor_ff;
  logic signed [15:0] ceil_ff;
  logic init_pending_ff;
  logic [`SEL_WIDTH-1:0] sel_ff [`NUM_CONTACTS];
  logic signed [15:0] target_ff;
  progress_t resume_ff;
  step_entry_t steps_ff [`NUM_STEPS];
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic [15:0] soak_cnt_ff;
  logic [15:0] nxt_soak_cnt;
  logic signed [15:0] setpoint_ff;
  logic [15:0] frac_ff;
  logic [15:0] nxt_frac;
  logic [3:0] group_ff;
  logic inhibit_ff;
  progress_t progress_ff;
  logic nv_write_ff;
  progress_t nv_record_ff;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_en;
  logic pwr_ret;
  logic step_en;
  logic inhibit;
  logic load_meas;
  logic seq_stop;
  logic resumed;
  logic type_to_step;
  logic rate_tick;
  logic step_move;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;
  logic [2:0] last_step;
  logic [`NUM_CONTACTS-1:0] ramp_ctl_hit;
  step_entry_t cur;
  logic [15:0] rate;
  logic signed [15:0] target_raw;
  logic signed [15:0] target_c;
  logic signed [15:0] meas_c;
  logic signed [15:0] setpoint_c;

  function automatic logic in_step_table(input logic [7:0] a);
    return (a >= `ADDR_STEP_BASE) && (a <= `ADDR_STEP_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] step_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - `ADDR_STEP_BASE;
    return off[6:4];
  endfunction

  function automatic logic reg_write(input logic w, input logic [7:0] a,
                                     input logic [7:0] target);
    return w && (a == target);
  endfunction

  tick_gen #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .sec_tick(sec_tick),
    .min_tick(min_tick),
    .hour_tick(hour_tick)
  );

  bound_clamp u_target_clamp (
    .bound_a(floor_ff),
    .bound_b(ceil_ff),
    .value(target_raw),
    .lo(),
    .hi(),
    .clamped(target_c)
  );

  bound_clamp u_meas_clamp (
    .bound_a(floor_ff),
    .bound_b(ceil_ff),
    .value(measured_value),
    .lo(),
    .hi(),
    .clamped(meas_c)
  );

  bound_clamp u_setpoint_clamp (
    .bound_a(floor_ff),
    .bound_b(ceil_ff),
    .value(setpoint_ff),
    .lo(),
    .hi(),
    .clamped(setpoint_c)
  );

  // APB: zero wait states, answer prepared during the setup cycle
  assign wr_en = psel & penable & pwrite & pready_ff;
  assign pwr_ret = reg_write(wr_en, paddr, `ADDR_CONTROL) & pwdata[`CTL_PWR_RET];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (in_step_table(paddr)) begin
      unique case (paddr[3:2])
        `STEP_FLD_TARGET: rd_data[15:0] = steps_ff[step_index(paddr)].target;
        `STEP_FLD_RATE: rd_data[15:0] = steps_ff[step_index(paddr)].rate;
        `STEP_FLD_DUR: rd_data[15:0] = steps_ff[step_index(paddr)].dur;
        `STEP_FLD_GROUP: rd_data[3:0] = steps_ff[step_index(paddr)].grp;
      endcase
    end else begin
      case (paddr)
        `ADDR_CONTROL: rd_data[`CTL_REMOTE:`CTL_RUN] = {remote_req_ff, run_ff};
        `ADDR_CONFIG: rd_data[7:0] = {unit_ff, type_ff, count_ff};
        `ADDR_RANGE: rd_data[7:0] = range_type_ff;
        `ADDR_FLOOR: rd_data[15:0] = floor_ff;
        `ADDR_CEILING: rd_data[15:0] = ceil_ff;
        `ADDR_CONTACT: rd_data[24:0] = {sel_ff[4], sel_ff[3], sel_ff[2], sel_ff[1], sel_ff[0]};
        `ADDR_TARGET: rd_data[15:0] = target_ff;
        `ADDR_RESUME: rd_data[4:0] = resume_ff;
        `ADDR_STATUS: rd_data[7:0] = {remote_active_ff, inhibit_ff, run_ff, progress_ff};
        `ADDR_SETPOINT: rd_data[15:0] = setpoint_ff;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~rd_ok;
      prdata_ff <= (psel & ~penable & ~pwrite & rd_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= `COUNT_RST;
      type_ff <= `TYPE_RST;
      unit_ff <= `UNIT_RST;
      range_type_ff <= `RANGE_RST;
      target_ff <= 16'sh0000;
      resume_ff <= '0;
      remote_req_ff <= 1'b0;
    end else begin
      if (reg_write(wr_en, paddr, `ADDR_CONFIG)) begin
        // Step counts outside 1..8 are refused
        if (pwdata[`CFG_COUNT_LSB +: 4] >= `COUNT_MIN &&
            pwdata[`CFG_COUNT_LSB +: 4] <= `COUNT_MAX) begin
          count_ff <= pwdata[`CFG_COUNT_LSB +: 4];
        end
        type_ff <= pwdata[`CFG_TYPE_LSB +: 2];
        if (pwdata[`CFG_UNIT_LSB +: 2] != 2'h3) begin
          unit_ff <= pwdata[`CFG_UNIT_LSB +: 2];
        end
      end
      if (reg_write(wr_en, paddr, `ADDR_RANGE)) begin
        range_type_ff <= pwdata[7:0];
      end
      if (reg_write(wr_en, paddr, `ADDR_TARGET)) begin
        target_ff <= pwdata[15:0];
      end
      if (reg_write(wr_en, paddr, `ADDR_RESUME)) begin
        resume_ff <= pwdata[4:0];
      end
      if (reg_write(wr_en, paddr, `ADDR_CONTROL)) begin
        remote_req_ff <= pwdata[`CTL_REMOTE];
      end
    end
  end

  // Bounds load from the input span after reset and on every range type write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      floor_ff <= 16'sh0000;
      ceil_ff <= 16'sh0000;
      init_pending_ff <= 1'b1;
    end else begin
      init_pending_ff <= 1'b0;
      if (init_pending_ff || reg_write(wr_en, paddr, `ADDR_RANGE)) begin
        floor_ff <= span_low;
        ceil_ff <= span_high;
      end else begin
        if (reg_write(wr_en, paddr, `ADDR_FLOOR)) begin
          floor_ff <= pwdata[15:0];
        end
        if (reg_write(wr_en, paddr, `ADDR_CEILING)) begin
          ceil_ff <= pwdata[15:0];
        end
      end
    end
  end

  // Contact function selectors and step table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NUM_CONTACTS; i++) begin
        sel_ff[i] <= `SEL_NONE;
      end
    end else if (reg_write(wr_en, paddr, `ADDR_CONTACT)) begin
      for (int i = 0; i < `NUM_CONTACTS; i++) begin
        sel_ff[i] <= pwdata[i*`SEL_WIDTH +: `SEL_WIDTH];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NUM_STEPS; i++) begin
        steps_ff[i] <= '{target: 16'sh0000, rate: 16'h0000, dur: 16'h0000, grp: `GROUP_RST};
      end
    end else if (wr_en && in_step_table(paddr)) begin
      unique case (paddr[3:2])
        `STEP_FLD_TARGET: steps_ff[step_index(paddr)].target <= pwdata[15:0];
        `STEP_FLD_RATE: steps_ff[step_index(paddr)].rate <= pwdata[15:0];
        `STEP_FLD_DUR: steps_ff[step_index(paddr)].dur <= pwdata[15:0];
        `STEP_FLD_GROUP: steps_ff[step_index(paddr)].grp <= pwdata[3:0];
      endcase
    end
  end

  // Ramp suspend: any contact set to ramp control and closed stops ramping
  genvar gc;
  generate
    for (gc = 0; gc < `NUM_CONTACTS; gc++) begin : g_contact
      assign ramp_ctl_hit[gc] = (sel_ff[gc] == `SEL_RAMP_CTL) & contact_state[gc];
    end
  endgenerate
  assign inhibit = |ramp_ctl_hit;

  assign step_en = type_ff[1];
  assign last_step = 3'(count_ff - `COUNT_MIN);
  assign cur = steps_ff[step_ff];
  assign target_raw = step_en ? cur.target : target_ff;
  assign rate = step_en ? cur.rate : steps_ff[0].rate;
  assign type_to_step = reg_write(wr_en, paddr, `ADDR_CONFIG) & run_ff & ~type_ff[1] &
                        pwdata[`CFG_TYPE_LSB + 1];

  always_comb begin
    unique case (unit_ff)
      `UNIT_PER_SEC: rate_tick = sec_tick;
      `UNIT_PER_MIN: rate_tick = min_tick;
      `UNIT_PER_HOUR: rate_tick = hour_tick;
      default: rate_tick = 1'b0;
    endcase
  end

  // Step programme sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_soak_cnt = soak_cnt_ff;
    load_meas = 1'b0;
    seq_stop = 1'b0;
    resumed = 1'b0;
    if (pwr_ret && resume_ff.running && step_en) begin
      if (type_ff == `TYPE_STEP_STOP) begin
        nxt_state = ST_IDLE;
        nxt_step = 3'h0;
        seq_stop = 1'b1;
      end else begin
        resumed = 1'b1;
        nxt_step = resume_ff.step;
        nxt_soak_cnt = 16'h0000;
        if (resume_ff.soak) begin
          nxt_state = ST_SOAK;
        end else if (|measurement_alarm_pair) begin
          nxt_state = ST_SOAK;
        end else begin
          nxt_state = ST_RAMP;
          load_meas = 1'b1;
        end
      end
    end else if (!run_ff || !step_en) begin
      nxt_state = ST_IDLE;
      nxt_step = 3'h0;
      nxt_soak_cnt = 16'h0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_RAMP;
          nxt_step = 3'h0;
        end
        ST_RAMP: begin
          if (setpoint_ff == target_c) begin
            nxt_state = ST_SOAK;
            nxt_soak_cnt = 16'h0000;
          end
        end
        ST_SOAK: begin
          if (soak_cnt_ff >= cur.dur) begin
            nxt_soak_cnt = 16'h0000;
            if (step_ff >= last_step) begin
              nxt_state = ST_IDLE;
              nxt_step = 3'h0;
              seq_stop = 1'b1;
            end else begin
              nxt_state = ST_RAMP;
              nxt_step = step_ff + 3'h1;
            end
          end else if (sec_tick) begin
            nxt_soak_cnt = soak_cnt_ff + 16'h0001;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_step = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      step_ff <= 3'h0;
      soak_cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      soak_cnt_ff <= nxt_soak_cnt;
    end
  end

  // Run mode: software sets it, the sequencer drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 1'b0;
    end else if (seq_stop || type_to_step) begin
      run_ff <= 1'b0;
    end else if (resumed) begin
      run_ff <= 1'b1;
    end else if (reg_write(wr_en, paddr, `ADDR_CONTROL)) begin
      run_ff <= pwdata[`CTL_RUN];
    end
  end

  // Working setpoint; rates count tenths of a setpoint unit
  assign step_move = (frac_ff >= `FRAC_ONE);
  assign nxt_frac = frac_ff - (step_move ? `FRAC_ONE : 16'h0000) +
                    (rate_tick ? rate : 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_ff <= 16'sh0000;
      frac_ff <= 16'h0000;
    end else if (load_meas) begin
      setpoint_ff <= meas_c;
      frac_ff <= 16'h0000;
    end else if (setpoint_ff != setpoint_c) begin
      setpoint_ff <= setpoint_c;
      frac_ff <= 16'h0000;
    end else if (step_en && state_ff != ST_RAMP) begin
      if (state_ff == ST_SOAK) begin
        setpoint_ff <= target_c;
      end
      frac_ff <= 16'h0000;
    end else if (inhibit || rate == 16'h0000) begin
      setpoint_ff <= target_c;
      frac_ff <= 16'h0000;
    end else if (setpoint_ff == target_c) begin
      frac_ff <= 16'h0000;
    end else begin
      // Single-unit moves toward the target cannot overshoot
      if (step_move) begin
        setpoint_ff <= (setpoint_ff < target_c) ? setpoint_ff + 16'sh0001 :
                       setpoint_ff - 16'sh0001;
      end
      frac_ff <= nxt_frac;
    end
  end

  // Outputs and progress log
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_ff <= `GROUP_RST;
      inhibit_ff <= 1'b0;
      remote_active_ff <= 1'b0;
      progress_ff <= '0;
    end else begin
      group_ff <= cur.grp;
      inhibit_ff <= inhibit;
      remote_active_ff <= remote_req_ff & ~step_en;
      progress_ff <= '{running: state_ff != ST_IDLE, soak: state_ff == ST_SOAK,
                       step: step_ff};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_write_ff <= 1'b0;
      nv_record_ff <= '0;
    end else begin
      nv_write_ff <= (type_ff == `TYPE_STEP_RESUME) && run_ff && !resumed &&
                     (nxt_state != state_ff || nxt_step != step_ff);
      nv_record_ff <= '{running: nxt_state != ST_IDLE, soak: nxt_state == ST_SOAK,
                        step: nxt_step};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign working_setpoint = setpoint_ff;
  assign tuning_group = group_ff;
  assign progress = progress_ff;
  assign remote_source_active = remote_active_ff;
  assign ramp_inhibited = inhibit_ff;
  assign nv_write = nv_write_ff;
  assign nv_record = nv_record_ff;
endmodule

// ==== verif/sequencer_properties.sv ====
// Port-level properties of the setpoint step sequencer
`timescale 1ns/10ps
module sequencer_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer outputs
  input wire sequencer_pkg::progress_t progress,
  input wire logic nv_write,
  input wire sequencer_pkg::progress_t nv_record
);
  import sequencer_pkg::*;
  logic acc;
  assign acc = psel && penable;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_access: assert property (acc |-> pready)
    else $error("no ready in access cycle");
  chk_ready_only: assert property (pready |-> acc && $past(psel && !penable))
    else $error("ready outside access cycle");
  chk_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  chk_err_hole: assert property (acc && paddr > 8'h24 && paddr < 8'h40 |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && paddr[1:0] == 2'h0 &&
      (paddr <= 8'h24 || (paddr >= 8'h40 && paddr <= 8'hBC)) |-> !pslverr)
    else $error("mapped access refused");
  chk_rdata_quiet: assert property (!(acc && !pwrite) || pslverr |-> prdata == 32'h0)
    else $error("read data outside valid read");
  chk_log_record: assert property (nv_write |=> progress == $past(nv_record))
    else $error("logged record differs from progress");
  chk_standby_home: assert property (!progress.running |->
      progress.step == 3'h0 && !progress.soak)
    else $error("standby not at start of first step");
endmodule
bind setpoint_step_sequencer sequencer_properties chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .progress, .nv_write, .nv_record);

// ==== verif/tb_top.sv ====
// Self-checking bench for the setpoint step sequencer
`timescale 1ns/10ps
`include "sequencer_params.svh"
module tb_top;
  import sequencer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, remote_source_active, ramp_inhibited, nv_write;
  logic signed [15:0] measured_value = 16'h0000;
  logic signed [15:0] span_low = 16'hFF9C;
  logic signed [15:0] span_high = 16'h03E8;
  logic signed [15:0] working_setpoint;
  logic [1:0] measurement_alarm_pair = 2'h0;
  logic [4:0] contact_state = 5'h00;
  logic [3:0] tuning_group;
  progress_t progress, nv_record;
  int mismatches = 0;
  int n_compared = 0;
  int nv_n = 0;
  setpoint_step_sequencer #(.SEC_CYCLES(20)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .measured_value,
    .span_low, .span_high, .measurement_alarm_pair, .contact_state,
    .working_setpoint, .tuning_group, .progress, .remote_source_active, .ramp_inhibited,
    .nv_write, .nv_record);
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (nv_write === 1'b1) nv_n <= nv_n + 1;
  task automatic cmp(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, s, x);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic till(input logic [4:0] p);
    for (int i = 0; i < 400 && progress !== p; i++) @(posedge pclk);
    #1;
  endtask
  task automatic t_defaults;
    xfer(`ADDR_CONFIG, 1'b0, 32'h0);
    cmp(r, 32'h41);
    xfer(`ADDR_CONTACT, 1'b0, 32'h0);
    cmp(r, 32'h0);
    xfer(`ADDR_FLOOR, 1'b0, 32'h0);
    cmp(r, 32'hFF9C);
    xfer(`ADDR_CEILING, 1'b0, 32'h0);
    cmp(r, 32'h3E8);
    xfer(8'h28, 1'b0, 32'h0);
    cmp(e, 32'h1);
  endtask
  task automatic t_clamp;
    xfer(`ADDR_FLOOR, 1'b1, 32'h1F4);
    xfer(`ADDR_CEILING, 1'b1, 32'hC8);
    xfer(`ADDR_TARGET, 1'b1, 32'h384);
    xfer(`ADDR_SETPOINT, 1'b0, 32'h0);
    cmp(working_setpoint, 32'h1F4);
    xfer(`ADDR_TARGET, 1'b1, 32'hFFCE);
    xfer(`ADDR_SETPOINT, 1'b0, 32'h0);
    cmp(working_setpoint, 32'hC8);
    span_high <= 16'h0320;
    xfer(`ADDR_RANGE, 1'b1, 32'h5);
    xfer(`ADDR_FLOOR, 1'b0, 32'h0);
    cmp(r, 32'hFF9C);
    xfer(`ADDR_CEILING, 1'b0, 32'h0);
    cmp(r, 32'h320);
  endtask
  task automatic t_contact;
    xfer(8'h44, 1'b1, 32'h5);
    xfer(`ADDR_CONTACT, 1'b1, 32'h3400);
    contact_state <= 5'h01;
    xfer(`ADDR_TARGET, 1'b1, 32'h12C);
    xfer(`ADDR_STATUS, 1'b0, 32'h0);
    cmp(ramp_inhibited, 32'h0);
    cmp(working_setpoint, 32'hFFFFFFCE);
    contact_state <= 5'h04;
    xfer(`ADDR_STATUS, 1'b0, 32'h0);
    cmp(ramp_inhibited, 32'h1);
    cmp(working_setpoint, 32'h12C);
    contact_state <= 5'h00;
    xfer(`ADDR_CONTACT, 1'b1, 32'h0);
  endtask
  task automatic t_step;
    xfer(8'h40, 1'b1, 32'h96);
    xfer(8'h44, 1'b1, 32'h0);
    xfer(8'h48, 1'b1, 32'h2);
    xfer(8'h4C, 1'b1, 32'h3);
    xfer(8'h50, 1'b1, 32'hFA);
    xfer(8'h58, 1'b1, 32'h9);
    xfer(`ADDR_CONFIG, 1'b1, 32'h32);
    xfer(`ADDR_CONTROL, 1'b1, 32'h1);
    till(5'h18);
    cmp(progress, 32'h18);
    cmp(working_setpoint, 32'h96);
    cmp(tuning_group, 32'h3);
    till(5'h11);
    cmp(progress, 32'h11);
    till(5'h00);
    cmp(progress, 32'h0);
    xfer(`ADDR_CONTROL, 1'b0, 32'h0);
    cmp(r[0], 32'h0);
    cmp(nv_n, 32'h5);
  endtask
  task automatic t_modes;
    xfer(`ADDR_CONFIG, 1'b1, 32'h12);
    xfer(`ADDR_CONTROL, 1'b1, 32'h3);
    xfer(`ADDR_STATUS, 1'b0, 32'h0);
    cmp(remote_source_active, 32'h1);
    xfer(`ADDR_CONFIG, 1'b1, 32'h22);
    xfer(`ADDR_CONTROL, 1'b0, 32'h0);
    cmp(r[0], 32'h0);
    cmp(remote_source_active, 32'h0);
  endtask
  task automatic t_resume;
    xfer(`ADDR_CONTROL, 1'b1, 32'h1);
    xfer(`ADDR_RESUME, 1'b1, 32'h11);
    xfer(`ADDR_CONTROL, 1'b1, 32'h5);
    xfer(`ADDR_CONTROL, 1'b0, 32'h0);
    cmp(r[0], 32'h0);
    cmp(progress, 32'h0);
    xfer(`ADDR_CONFIG, 1'b1, 32'hB2);
    xfer(8'h54, 1'b1, 32'h5);
    measured_value <= 16'h0028;
    for (int i = 0; i < 3; i++) begin
      measurement_alarm_pair <= (i == 1) ? 2'h1 : 2'h0;
      xfer(`ADDR_RESUME, 1'b1, (i == 0) ? 32'h19 : 32'h11);
      xfer(`ADDR_CONTROL, 1'b1, 32'h5);
      xfer(`ADDR_STATUS, 1'b0, 32'h0);
      cmp(progress, (i == 2) ? 32'h11 : 32'h19);
    end
    cmp(working_setpoint, 32'h28);
    xfer(`ADDR_CONTROL, 1'b1, 32'h0);
  endtask
  task automatic t_rate;
    xfer(8'h44, 1'b1, 32'h19);
    xfer(`ADDR_TARGET, 1'b1, 32'h32);
    xfer(`ADDR_CONFIG, 1'b1, 32'h2);
    repeat (30) @(posedge pclk);
    cmp(working_setpoint > 16'sh0028 && working_setpoint < 16'sh0032, 32'h1);
    repeat (200) @(posedge pclk);
    cmp(working_setpoint, 32'h32);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_clamp();
    t_contact();
    t_step();
    t_modes();
    t_resume();
    t_rate();
    wrap_up();
  end
endmodule
